// ===== verilog/atsb_pkg.sv
// Constants shared by the async timer synchroniser bridge.
package atsb_pkg;
  // ==========================================================
  // Register map
  localparam logic [2:0] ATSB_ADDR_CNT = 3'h0;
  localparam logic [2:0] ATSB_ADDR_CMPA = 3'h1;
  localparam logic [2:0] ATSB_ADDR_CMPB = 3'h2;
  localparam logic [2:0] ATSB_ADDR_CTLA = 3'h3;
  localparam logic [2:0] ATSB_ADDR_CTLB = 3'h4;
  localparam logic [2:0] ATSB_ADDR_STAT = 3'h5;
  localparam logic [2:0] ATSB_ADDR_GTC = 3'h6;
  localparam logic [2:0] ATSB_ADDR_SLEEP = 3'h7;
  // ==========================================================
  // Status and GTC register fields, reset values
  localparam int ATSB_BIT_EXTCLK = 6;
  localparam int ATSB_BIT_ASYNC = 5;
  localparam int ATSB_PEND_MSB = 4;
  localparam int ATSB_BIT_PSR = 1;
  localparam logic [7:0] ATSB_STAT_RST = 8'h00;
  localparam logic [7:0] ATSB_REG_RST = 8'h00;
  // ==========================================================
  // Timing
  localparam int ATSB_WAKE_HOLD = 4;
  localparam int ATSB_FLAG_CPU_CYC = 3;
  localparam logic [9:0] ATSB_DIV8 = 10'h007;
  localparam logic [9:0] ATSB_DIV32 = 10'h01f;
  localparam logic [9:0] ATSB_DIV64 = 10'h03f;
  localparam logic [9:0] ATSB_DIV128 = 10'h07f;
  localparam logic [9:0] ATSB_DIV256 = 10'h0ff;
  localparam logic [9:0] ATSB_DIV1024 = 10'h3ff;
endpackage : atsb_pkg

// ===== verilog/atsb_bridge.sv
// Async timer bridge: holding registers, counter sync, flag sync.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
// Functional notes
// [RL1] Async writes land after two pin edges
// [RL2] Five independent holding registers
// [RL3] Pending flags set on write, cleared
// [RL4] Counter reads live; others read holding
// [RL5] Counter copy refreshed on each pin edge
// [RL6] Software avoids writing while pending
// [RL7] Compare match blocked while write pending
// [RL8] Flags cross in three cycles plus tick
// [RL9] Compare pin driven from timer domain
// [RL10] Wake begins on next timer tick
// [RL11] Processor held four cycles after wake
// [RL12] Interrupt logic rearms after one tick
// [RL13] Select bit chooses I/O or pin clock
// [RL14] Software follows safe clock switch order
// [RL15] External clock buffer versus crystal enable
// [RL16] Async mode detaches oscillator pins
// [RL17] Prescaler taps and stop
// [RL18] Prescaler reset bit resets prescaler
// [RL19] CPU clock over four times oscillator
// [RL20] Oscillator runs except deep sleep modes
// [RL21] Software waits pending before sleeping
// [RL22] Software read sequence after wake
// [RL23] Three-bit divider select encoding
// [RL24] Async prescaler reset holds until done
// [RL25] Pending clears synchronised back
module atsb_bridge import atsb_pkg::*; #(
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DW-1:0] rdata,
  input wire logic async_osc_in_pin,
  input wire logic [DW-1:0] timer_count,
  input wire logic [2:0] timer_irq_cond,
  output logic [DW-1:0] counter_load,
  output logic counter_load_stb,
  output logic [DW-1:0] compare_value_a,
  output logic [DW-1:0] compare_value_b,
  output logic [DW-1:0] timer_control_a,
  output logic [DW-1:0] timer_control_b,
  output logic compare_match_enable,
  output logic timer_tick,
  output logic [2:0] irq_flags,
  output logic wake_req,
  output logic cpu_hold,
  output logic ext_clock_buf_en,
  output logic crystal_osc_en,
  output logic osc_pins_detached
);
  // ==========================================================
  // Pin synchroniser and edge detection
  logic [2:0] pin_sync_r;
  logic pin_rise;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], async_osc_in_pin};
    end
  end
  // Stage 0 feeds only stage 1; edges are taken from later stages.
  assign pin_rise = pin_sync_r[1] & ~pin_sync_r[2];

  // ==========================================================
  // Software registers
  logic [7:0] stat_r;
  logic [7:0] hold_r [0:4];
  logic [4:0] pend_r;
  logic [4:0] edge_cnt_r [0:4];
  logic [DW-1:0] cnt_view_r;
  logic [2:0] sleep_mode_r;
  logic psr_r;
  logic sync_hold_r;
  logic async_mode;
  assign async_mode = stat_r[ATSB_BIT_ASYNC];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_r <= ATSB_STAT_RST;
      sleep_mode_r <= 3'h0;
      sync_hold_r <= 1'b0;
    end else if (wr && addr == ATSB_ADDR_STAT) begin
      stat_r <= {1'b0, wdata[6:5], 5'h00};
    end else if (wr && addr == ATSB_ADDR_SLEEP) begin
      sleep_mode_r <= wdata[2:0];
    end else if (wr && addr == ATSB_ADDR_GTC) begin
      sync_hold_r <= wdata[7];
    end
  end

  // ==========================================================
  // Holding registers, one per async register
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_hold
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          hold_r[gi] <= ATSB_REG_RST;
          pend_r[gi] <= 1'b0;
          edge_cnt_r[gi] <= 5'h0;
        end else if (wr && addr == 3'(gi)) begin
          hold_r[gi] <= wdata; // see [RL2]
          pend_r[gi] <= async_mode; // see [RL3]
          edge_cnt_r[gi] <= 5'h0;
        end else if (pend_r[gi] && pin_rise) begin
          // Second pin edge after the write commits the value.
          if (edge_cnt_r[gi] == 5'h1) begin
            pend_r[gi] <= 1'b0; // see [RL1] see [RL25]
          end
          edge_cnt_r[gi] <= edge_cnt_r[gi] + 5'h1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Destination registers
  logic [4:0] pend_d_r;
  logic wr_cnt_d_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_d_r <= 5'h0;
      wr_cnt_d_r <= 1'b0;
      counter_load <= ATSB_REG_RST;
      counter_load_stb <= 1'b0;
      compare_value_a <= ATSB_REG_RST;
      compare_value_b <= ATSB_REG_RST;
      timer_control_a <= ATSB_REG_RST;
      timer_control_b <= ATSB_REG_RST;
    end else begin
      pend_d_r <= pend_r;
      // Sync mode updates straight away; async waits for the commit.
      wr_cnt_d_r <= !async_mode && wr && addr == ATSB_ADDR_CNT;
      counter_load_stb <= wr_cnt_d_r ||
                          (pend_d_r[0] && !pend_r[0]); // see [RL1]
      if (!async_mode || (pend_d_r[0] && !pend_r[0])) begin
        counter_load <= hold_r[0];
      end
      if (!async_mode || (pend_d_r[1] && !pend_r[1])) begin
        compare_value_a <= hold_r[1];
      end
      if (!async_mode || (pend_d_r[2] && !pend_r[2])) begin
        compare_value_b <= hold_r[2];
      end
      if (!async_mode || (pend_d_r[3] && !pend_r[3])) begin
        timer_control_a <= hold_r[3];
      end
      if (!async_mode || (pend_d_r[4] && !pend_r[4])) begin
        timer_control_b <= hold_r[4];
      end
    end
  end

  // ==========================================================
  // Counter view and compare gating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_view_r <= ATSB_REG_RST;
      compare_match_enable <= 1'b1;
    end else begin
      if (!async_mode || pin_rise) begin
        cnt_view_r <= timer_count; // see [RL5]
      end
      compare_match_enable <= ~|pend_r[2:0]; // see [RL7] see [RL9]
    end
  end

  // ==========================================================
  // Clock source and pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_clock_buf_en <= 1'b0;
      crystal_osc_en <= 1'b0;
      osc_pins_detached <= 1'b0;
    end else begin
      ext_clock_buf_en <= async_mode & stat_r[ATSB_BIT_EXTCLK]; // see [RL15]
      // Oscillator stops in power-down (2) and standby (6).
      crystal_osc_en <= async_mode & ~stat_r[ATSB_BIT_EXTCLK] &
                        sleep_mode_r != 3'h2 &&
                        sleep_mode_r != 3'h6; // see [RL20]
      osc_pins_detached <= async_mode; // see [RL16]
    end
  end

  // ==========================================================
  // Prescaler
  logic [9:0] presc_r;
  logic src_tick;
  logic presc_tap;
  assign src_tick = async_mode ? pin_rise : 1'b1; // see [RL13]
  always_comb begin
    case (hold_r[4][2:0]) // see [RL23] see [RL17]
      3'h0: presc_tap = 1'b0;
      3'h1: presc_tap = src_tick;
      3'h2: presc_tap = src_tick && (presc_r & ATSB_DIV8) == ATSB_DIV8;
      3'h3: presc_tap = src_tick && (presc_r & ATSB_DIV32) == ATSB_DIV32;
      3'h4: presc_tap = src_tick && (presc_r & ATSB_DIV64) == ATSB_DIV64;
      3'h5: presc_tap = src_tick && (presc_r & ATSB_DIV128) == ATSB_DIV128;
      3'h6: presc_tap = src_tick && (presc_r & ATSB_DIV256) == ATSB_DIV256;
      default: presc_tap = src_tick &&
                           (presc_r & ATSB_DIV1024) == ATSB_DIV1024;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc_r <= 10'h0;
      psr_r <= 1'b0;
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= presc_tap & timer_control_b[2:0] != 3'h0;
      if (wr && addr == ATSB_ADDR_GTC && wdata[ATSB_BIT_PSR]) begin
        psr_r <= 1'b1; // see [RL18]
      end else if (psr_r && !sync_hold_r && (!async_mode || pin_rise)) begin
        psr_r <= 1'b0; // see [RL24]
      end
      if (psr_r && (!async_mode || pin_rise)) begin
        presc_r <= 10'h0; // see [RL18]
      end else if (src_tick) begin
        presc_r <= presc_r + 10'h1;
      end
    end
  end

  // ==========================================================
  // Interrupt flag crossing and wake-up
  typedef enum logic [1:0] {ATSB_IDLE, ATSB_WAIT, ATSB_HOLD, ATSB_REARM}
    atsb_wake_t;
  atsb_wake_t wake_st_r;
  logic [2:0] cond_lat_r;
  logic [2:0] flag_pipe_r [0:2];
  logic [2:0] hold_cnt_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_lat_r <= 3'h0;
      flag_pipe_r[0] <= 3'h0;
      flag_pipe_r[1] <= 3'h0;
      flag_pipe_r[2] <= 3'h0;
      irq_flags <= 3'h0;
    end else begin
      // Condition captured on a timer tick, then three CPU stages.
      if (!async_mode || pin_rise) begin
        cond_lat_r <= timer_irq_cond; // see [RL8]
      end
      flag_pipe_r[0] <= cond_lat_r;
      flag_pipe_r[1] <= flag_pipe_r[0];
      flag_pipe_r[2] <= flag_pipe_r[1];
      irq_flags <= flag_pipe_r[1] & ~flag_pipe_r[2]; // see [RL8]
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_st_r <= ATSB_IDLE;
      hold_cnt_r <= 3'h0;
      wake_req <= 1'b0;
      cpu_hold <= 1'b0;
    end else begin
      case (wake_st_r)
        ATSB_IDLE: begin
          // The raw condition lives in the pin domain; use the latched copy.
          if (|cond_lat_r) begin
            wake_st_r <= ATSB_WAIT;
          end
        end
        ATSB_WAIT: begin
          if (!async_mode || pin_rise) begin
            wake_req <= 1'b1; // see [RL10]
            cpu_hold <= 1'b1;
            hold_cnt_r <= 3'h0;
            wake_st_r <= ATSB_HOLD;
          end
        end
        ATSB_HOLD: begin
          wake_req <= 1'b0;
          hold_cnt_r <= hold_cnt_r + 3'h1;
          if (hold_cnt_r == 3'(ATSB_WAKE_HOLD - 1)) begin
            cpu_hold <= 1'b0; // see [RL11]
            wake_st_r <= ATSB_REARM;
          end
        end
        ATSB_REARM: begin
          if (!async_mode || pin_rise) begin
            wake_st_r <= ATSB_IDLE; // see [RL12]
          end
        end
        default: wake_st_r <= ATSB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        ATSB_ADDR_CNT: rdata <= cnt_view_r; // see [RL4]
        ATSB_ADDR_CMPA: rdata <= hold_r[1];
        ATSB_ADDR_CMPB: rdata <= hold_r[2];
        ATSB_ADDR_CTLA: rdata <= hold_r[3];
        ATSB_ADDR_CTLB: rdata <= hold_r[4];
        ATSB_ADDR_STAT: rdata <= {stat_r[7:5], pend_r[0], pend_r[1],
                                  pend_r[2], pend_r[3], pend_r[4]}; // see [RL3]
        ATSB_ADDR_GTC: rdata <= {sync_hold_r, 5'h00, psr_r, 1'b0};
        default: rdata <= {5'h00, sleep_mode_r};
      endcase
    end
  end

  // ==========================================================
  // Checks
  property p_pend_set;
    @(posedge clk) disable iff (!rst_n)
      (wr && addr == ATSB_ADDR_CMPA && async_mode) |=> pend_r[1];
  endproperty
  a_pend_set: assert property (p_pend_set) // see [RL3]
    else $error("pending flag not set after async write");
  property p_cmp_block;
    @(posedge clk) disable iff (!rst_n)
      (|pend_r[2:0]) |=> !compare_match_enable;
  endproperty
  a_cmp_block: assert property (p_cmp_block) // see [RL7]
    else $error("compare match enabled while write pending");
  property p_hold4;
    @(posedge clk) disable iff (!rst_n)
      $rose(cpu_hold) |-> cpu_hold [*4] ##1 !cpu_hold;
  endproperty
  a_hold4: assert property (p_hold4) // see [RL11]
    else $error("cpu hold not four cycles");
  property p_pend_clear;
    @(posedge clk) disable iff (!rst_n)
      $fell(pend_r[0]) |-> $past(pin_rise) && $past(pend_r[0]);
  endproperty
  a_pend_clear: assert property (p_pend_clear) // see [RL1]
    else $error("pending cleared without pin edge");
  property p_detach;
    @(posedge clk) disable iff (!rst_n)
      ##1 osc_pins_detached == $past(async_mode);
  endproperty
  a_detach: assert property (p_detach) // see [RL16]
    else $error("pin detach does not follow async select");
  property p_psr_stay;
    @(posedge clk) disable iff (!rst_n)
      (psr_r && async_mode && !pin_rise && !wr) |=> psr_r;
  endproperty
  a_psr_stay: assert property (p_psr_stay) // see [RL24]
    else $error("prescaler reset bit cleared early");
  property p_stop;
    @(posedge clk) disable iff (!rst_n)
      (hold_r[4][2:0] == 3'h0) |-> !presc_tap;
  endproperty
  a_stop: assert property (p_stop) // see [RL23]
    else $error("tap active while stopped");
  property p_extbuf;
    @(posedge clk) disable iff (!rst_n)
      ext_clock_buf_en |-> !crystal_osc_en;
  endproperty
  a_extbuf: assert property (p_extbuf) // see [RL15]
    else $error("buffer and crystal both enabled");
endmodule : atsb_bridge

// ===== sim/atsb_osc_model.sv
// Far-side model: timer oscillator pin, counter core and conditions.
`timescale 1ns/10ps
module atsb_osc_model #(
  parameter realtime HALF_NS = 103.0
) (
  input wire logic [2:0] cond_req,
  output logic async_osc_in_pin,
  output logic [7:0] timer_count,
  output logic [2:0] timer_irq_cond
);
  // ==========================================================
  // Oscillator
  // The period stays well above four bus clocks and drifts against the
  // bus clock, so the bridge never sees a fixed phase.
  initial begin
    async_osc_in_pin = 1'b0;
    forever #(HALF_NS) async_osc_in_pin = ~async_osc_in_pin;
  end
  // ==========================================================
  // Counter core and conditions, both living in the pin domain
  initial timer_count = 8'h00;
  initial timer_irq_cond = 3'h0;
  always @(posedge async_osc_in_pin) begin
    timer_count <= timer_count + 8'h01;
    timer_irq_cond <= cond_req;
  end
endmodule : atsb_osc_model

// ===== sim/atsb_bridge_tb_top.sv
// Testbench for the async timer bridge: register tasks and scenarios.
`timescale 1ns/10ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); \
  end \
end
module atsb_bridge_tb_top import atsb_pkg::*; ;
  // ==========================================================
  // Signals
  logic clk, rst_n, wr, rd, stb, cme, tick, wake, hold, ebuf, xosc, det;
  logic pin;
  logic [2:0] addr, cond, irq, tic;
  logic [7:0] wdata, rdata, cload, cva, cvb, tca, tcb, tcount, d, v;
  int n_mismatch, checks_done, i, n, n_stb;
  int divs[7] = '{1, 8, 32, 64, 128, 256, 1024};

  atsb_bridge dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .async_osc_in_pin(pin),
    .timer_count(tcount), .timer_irq_cond(tic), .counter_load(cload),
    .counter_load_stb(stb), .compare_value_a(cva), .compare_value_b(cvb),
    .timer_control_a(tca), .timer_control_b(tcb),
    .compare_match_enable(cme), .timer_tick(tick), .irq_flags(irq),
    .wake_req(wake), .cpu_hold(hold), .ext_clock_buf_en(ebuf),
    .crystal_osc_en(xosc), .osc_pins_detached(det));

  atsb_osc_model osc (.cond_req(cond), .async_osc_in_pin(pin),
    .timer_count(tcount), .timer_irq_cond(tic));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (stb === 1'b1) n_stb++;
  end
  // ==========================================================
  // Tasks
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] val);
    @(posedge clk);
    addr <= a;
    wdata <= val;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] val);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 val = rdata;
  endtask : rd_reg
  // Polls a pending bit; software must not rewrite until it clears.
  task automatic wait_clr(input int b);
    logic [7:0] s;
    int k;
    s = 8'hff;
    for (k = 0; k < 40 && s[b] !== 1'b0; k++) rd_reg(ATSB_ADDR_STAT, s);
    `CHK(s[b], 1'b0);
  endtask : wait_clr
  // The first two gaps after a divider change are skipped as the first one's phase is open.
  task automatic tick_gap(output int g);
    int k;
    repeat (2) begin
      for (k = 0; k < 3000 && tick !== 1'b1; k++) step();
      step();
    end
    for (g = 1; g < 3000 && tick !== 1'b1; g++) step();
  endtask : tick_gap
  function automatic logic [7:0] dst(input int k);
    case (k)
      0: dst = cload;
      1: dst = cva;
      2: dst = cvb;
      3: dst = tca;
      default: dst = tcb;
    endcase
  endfunction : dst
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // ==========================================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  // ==========================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    cond = 3'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ATSB_ADDR_STAT, d);
    `CHK(d, ATSB_STAT_RST);
    `CHK(cme, 1'b1);
    `CHK(det, 1'b0);
    wr_reg(ATSB_ADDR_CMPA, 8'h11);
    repeat (2) step();
    `CHK(cva, 8'h11);
    $display("test reset and sync write done");
    for (i = 0; i < 7; i++) begin
      wr_reg(ATSB_ADDR_CTLB, 8'(i + 1));
      tick_gap(n);
      `CHK(n, divs[i]);
    end
    wr_reg(ATSB_ADDR_CTLB, 8'h00);
    n = 0;
    repeat (3) step();
    repeat (100) begin
      step();
      if (tick === 1'b1) n++;
    end
    `CHK(n, 0);
    $display("test prescaler done");
    wr_reg(ATSB_ADDR_STAT, 8'hbf);
    repeat (2) step();
    rd_reg(ATSB_ADDR_STAT, d);
    `CHK(d, 8'h20);
    `CHK(det, 1'b1);
    `CHK(xosc, 1'b1);
    for (i = 0; i < 5; i++) begin
      v = 8'ha0 + 8'(i);
      wr_reg(3'(i), v);
      rd_reg(ATSB_ADDR_STAT, d);
      `CHK(d[4 - i], 1'b1);
      `CHK(dst(i) === v, 1'b0);
      if (i < 3) `CHK(cme, 1'b0);
      wait_clr(4 - i);
      step();
      `CHK(dst(i), v);
      `CHK(cme, 1'b1);
      rd_reg(3'(i), d);
      if (i > 0) `CHK(d, v);
    end
    `CHK(n_stb, 1);
    wr_reg(ATSB_ADDR_CMPB, 8'h5b);
    wr_reg(ATSB_ADDR_CTLA, 8'h5c);
    rd_reg(ATSB_ADDR_STAT, d);
    `CHK(d[2:1], 2'b11);
    wait_clr(2);
    wait_clr(1);
    `CHK({cvb, tca}, 16'h5b5c);
    @(posedge pin);
    repeat (6) step();
    rd_reg(ATSB_ADDR_CNT, d);
    `CHK(d, tcount);
    $display("test async writes done");
    cond <= 3'b001;
    for (n = 0; n < 40 && tic[0] !== 1'b1; n++) step();
    for (n = 0; n < 40 && irq[0] !== 1'b1; n++) step();
    `CHK(n >= ATSB_FLAG_CPU_CYC && n <= ATSB_FLAG_CPU_CYC + 24, 1'b1);
    cond <= 3'b000;
    wr_reg(ATSB_ADDR_SLEEP, 8'h03);
    repeat (30) step();
    cond <= 3'b010;
    for (n = 0; n < 40 && wake !== 1'b1; n++) step();
    `CHK(wake, 1'b1);
    for (n = 0; n < 10 && hold !== 1'b1; n++) step();
    for (n = 0; n < 20 && hold === 1'b1; n++) step();
    `CHK(n, ATSB_WAKE_HOLD);
    cond <= 3'b000;
    $display("test flags and wake done");
    wr_reg(ATSB_ADDR_SLEEP, 8'h02);
    repeat (2) step();
    `CHK(xosc, 1'b0);
    wr_reg(ATSB_ADDR_SLEEP, 8'h00);
    wr_reg(ATSB_ADDR_STAT, 8'h40);
    wr_reg(ATSB_ADDR_STAT, 8'h60);
    repeat (2) step();
    `CHK({ebuf, xosc}, 2'b10);
    $display("test oscillator control done");
    end_sim();
  end
endmodule : atsb_bridge_tb_top
